//--- rtl/lcdhp_host_port.sv
// parallel host port of a character lcd controller
`timescale 1ns/1ps
module lcdhp_host_port
  import lcdhp_pkg::*;
(
  input wire logic CLOCK_IN, // system clock, 50 MHz
  input wire logic RESETN_IN, // async reset, active low
  input wire logic STROBE_IN, // bus strobe pin
  input wire logic REG_SELECT_LINE_IN, // register select pin
  input wire logic READ_WRITE_IN, // high read, low write
  input wire logic [7:0] PARALLEL_DATA_LINES_IN, // data pins, input side
  output logic [7:0] PARALLEL_DATA_LINES_OUT, // data pins, output side
  output logic PARALLEL_DATA_LINES_OE_OUT, // high while driving data pins
  input wire logic SUB_ADDRESS_PIN_IN, // serial sub-address strap
  output logic [6:0] SERIAL_ADDR_OUT, // serial-bus device address
  input wire logic [7:0] MEM_RDATA_IN, // memory read data at pointer
  output logic MEM_WE_OUT, // memory write pulse
  output logic MEM_GLYPH_SEL_OUT, // 1 glyph memory, 0 display memory
  output logic [6:0] MEM_ADDR_OUT, // memory address
  output logic [7:0] MEM_WDATA_OUT, // memory write data
  output logic [7:0] INSTR_OUT, // instruction holding register
  output logic INSTR_VALID_OUT, // pulse: instruction accepted
  output logic BUSY_OUT, // busy flag
  output logic [2:0] BIAS_LEVELS_OUT, // selected bias level count
  output logic FRAME_TICK_OUT // one pulse per display frame
);
  lcdhp_state_s_t s_r;
  lcdhp_state_s_t s_nxt;
  logic instr_valid_r;
  logic instr_valid_nxt;
  logic [6:0] sub_sync_r;
  logic strobe_fall;
  logic [7:0] din;
  logic [7:0] bus_byte;
  logic byte_done;
  logic [7:0] status;

  // two-stage syncs; [0] is the first stage, read only by [1]
  logic [1:0] rs_sync_r;
  logic [1:0] rw_sync_r;
  logic [7:0] db_sync1_r;
  logic [7:0] db_sync2_r;

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      rs_sync_r <= 2'h0;
      rw_sync_r <= 2'h0;
      db_sync1_r <= 8'h00;
      db_sync2_r <= 8'h00;
      sub_sync_r <= 7'h00;
    end
    else
    begin
      rs_sync_r <= {rs_sync_r[0], REG_SELECT_LINE_IN};
      rw_sync_r <= {rw_sync_r[0], READ_WRITE_IN};
      db_sync1_r <= PARALLEL_DATA_LINES_IN;
      db_sync2_r <= db_sync1_r;
      // sub-address picks one of two addresses
      sub_sync_r <= {SER_ADDR_HI, SUB_ADDRESS_PIN_IN};
    end
  end

  // falling strobe edge from stages two and three only
  assign strobe_fall = s_r.strobe_sync[2] & ~s_r.strobe_sync[1];
  assign din = db_sync2_r;
  // busy on top line, pointer below
  assign status = {s_r.busy_cnt != 12'h000, s_r.addr};

  always_comb
  begin
    s_nxt = s_r;
    instr_valid_nxt = 1'b0;
    bus_byte = 8'h00;
    byte_done = 1'b0;
    s_nxt.strobe_sync = {s_r.strobe_sync[1:0], STROBE_IN};
    s_nxt.mem_we = 1'b0;
    // busy counts down and clears itself
    if (s_r.busy_cnt != 12'h000)
    begin
      s_nxt.busy_cnt = s_r.busy_cnt - 12'h001;
    end
    case (s_r.state)
      LCDHP_IDLE:
      begin
        if (strobe_fall)
        begin
          s_nxt.state = LCDHP_STROBE;
        end
      end
      LCDHP_STROBE:
      begin
        s_nxt.state = LCDHP_IDLE;
        // narrow bus pairs two nibbles, upper first; low lines ignored
        if (s_r.wide_bus)
        begin
          bus_byte = din;
          byte_done = 1'b1;
        end
        else if (!s_r.nibble_lo)
        begin
          s_nxt.nibble_hold = din[7:4];
          s_nxt.nibble_lo = 1'b1;
        end
        else
        begin
          bus_byte = {s_r.nibble_hold, din[7:4]};
          byte_done = 1'b1;
          s_nxt.nibble_lo = 1'b0;
        end
        if (rw_sync_r[1])
        begin
          s_nxt.dout_en = 1'b0;
          // data read finished, step pointer and refetch
          if (rs_sync_r[1] && byte_done)
          begin
            s_nxt.addr = s_r.addr_inc ? s_r.addr + 7'h01 : s_r.addr - 7'h01;
            s_nxt.state = LCDHP_BUSY;
          end
        end
        else if (byte_done)
        begin
          if (rs_sync_r[1])
          begin
            // data write into the transfer register and memory
            s_nxt.data = bus_byte;
            s_nxt.mem_we = 1'b1;
            s_nxt.mem_addr = s_r.addr;
            s_nxt.mem_wdata = bus_byte;
            s_nxt.addr = s_r.addr_inc ? s_r.addr + 7'h01 : s_r.addr - 7'h01;
            s_nxt.state = LCDHP_BUSY;
          end
          else if (s_r.busy_cnt == 12'h000)
          begin
            s_nxt.instr = bus_byte;
            instr_valid_nxt = 1'b1;
            s_nxt.busy_cnt = OP_CYCLES;
            if (bus_byte[7])
            begin
              s_nxt.addr = bus_byte[6:0];
              s_nxt.glyph_sel = 1'b0;
              s_nxt.state = LCDHP_BUSY;
            end
            else if (bus_byte[6])
            begin
              s_nxt.addr = {1'b0, bus_byte[5:0]};
              s_nxt.glyph_sel = 1'b1;
              s_nxt.state = LCDHP_BUSY;
            end
            else if (bus_byte[5])
            begin
              s_nxt.wide_bus = bus_byte[FUNC_DL_BIT];
              s_nxt.two_line = bus_byte[FUNC_N_BIT];
              s_nxt.nibble_lo = 1'b0;
            end
            else if (bus_byte[2])
            begin
              s_nxt.addr_inc = bus_byte[ENTRY_INC_BIT];
            end
          end
        end
      end
      LCDHP_BUSY:
      begin
        // reload transfer register from memory at new pointer
        // wait out the write pulse, which still steers the memory address
        if (!s_r.mem_we)
        begin
          s_nxt.data = MEM_RDATA_IN;
          s_nxt.state = LCDHP_IDLE;
        end
      end
      default:
      begin
        s_nxt.state = LCDHP_IDLE;
      end
    endcase
    // present read data while strobe high on a read
    if (s_r.strobe_sync[1] && !s_r.strobe_sync[2] && rw_sync_r[1])
    begin
      s_nxt.dout_en = 1'b1;
      if (rs_sync_r[1])
      begin
        bus_byte = s_r.data;
      end
      else
      begin
        bus_byte = status;
      end
      s_nxt.dout = (s_r.wide_bus || !s_r.nibble_lo) ? bus_byte : {bus_byte[3:0], 4'h0};
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      s_r <= '{state: LCDHP_IDLE, strobe_sync: 3'h0, instr: INSTR_RST, data: DATA_RST,
               addr: ADDR_RST, addr_inc: 1'b1, glyph_sel: 1'b0, wide_bus: 1'b1,
               two_line: 1'b0, nibble_lo: 1'b0, nibble_hold: 4'h0, busy_cnt: 12'h000,
               dout: 8'h00, dout_en: 1'b0, mem_we: 1'b0, mem_addr: 7'h00,
               mem_wdata: 8'h00};
      instr_valid_r <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
      instr_valid_r <= instr_valid_nxt;
    end
  end

  lcdhp_frame_div u_frame_div (
    .clk_in(CLOCK_IN),
    .resetn_in(RESETN_IN),
    .tick_out(FRAME_TICK_OUT)
  );

  assign PARALLEL_DATA_LINES_OUT = s_r.dout;
  assign PARALLEL_DATA_LINES_OE_OUT = s_r.dout_en;
  assign SERIAL_ADDR_OUT = sub_sync_r;
  assign MEM_WE_OUT = s_r.mem_we;
  assign MEM_GLYPH_SEL_OUT = s_r.glyph_sel;
  assign MEM_ADDR_OUT = s_r.mem_we ? s_r.mem_addr : s_r.addr;
  assign MEM_WDATA_OUT = s_r.mem_wdata;
  assign INSTR_OUT = s_r.instr;
  assign INSTR_VALID_OUT = instr_valid_r;
  assign BUSY_OUT = status[BUSY_BIT];
  assign BIAS_LEVELS_OUT = s_r.two_line ? BIAS_LEVELS_MUX32 : BIAS_LEVELS_MUX16;
endmodule

//--- rtl/lcdhp_pkg.sv
// constants and types for the lcd controller host port
package lcdhp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  // status byte layout
  localparam int BUSY_BIT = 7;
  // frame divider ratio
  localparam int FRAME_DIV = 2304;
  localparam logic [11:0] FRAME_DIV_LAST = 12'(FRAME_DIV - 1);
  // serial-bus address: fixed upper bits, low bit from sub-address pin
  localparam logic [5:0] SER_ADDR_HI = 6'h1D;
  // internal operation time
  localparam int OP_TIME_NS = 40000;
  localparam int CLK_PERIOD_NS = 20;
  localparam logic [11:0] OP_CYCLES = 12'(OP_TIME_NS / CLK_PERIOD_NS);
  // reset values
  localparam logic [7:0] INSTR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [6:0] ADDR_RST = 7'h00;
  // instruction codes decoded by the port
  localparam logic [7:0] OP_SET_GLYPH_ADDR = 8'h40;
  localparam logic [7:0] OP_SET_DISP_ADDR = 8'h80;
  localparam logic [7:0] OP_ENTRY_MODE = 8'h04;
  localparam logic [7:0] OP_FUNC_SET = 8'h20;
  localparam int ENTRY_INC_BIT = 1;
  localparam int FUNC_DL_BIT = 4;
  localparam int FUNC_N_BIT = 3;
  // bias levels per multiplex rate
  localparam logic [2:0] BIAS_LEVELS_MUX16 = 3'h5;
  localparam logic [2:0] BIAS_LEVELS_MUX32 = 3'h6;

  typedef enum logic [1:0] {
    LCDHP_IDLE = 2'b00,
    LCDHP_STROBE = 2'b01,
    LCDHP_BUSY = 2'b10
  } lcdhp_state_t;

  typedef struct packed {
    lcdhp_state_t state;
    logic [2:0] strobe_sync;
    logic [7:0] instr;
    logic [7:0] data;
    logic [6:0] addr;
    logic addr_inc;
    logic glyph_sel;
    logic wide_bus;
    logic two_line;
    logic nibble_lo;
    logic [3:0] nibble_hold;
    logic [11:0] busy_cnt;
    logic [7:0] dout;
    logic dout_en;
    logic mem_we;
    logic [6:0] mem_addr;
    logic [7:0] mem_wdata;
  } lcdhp_state_s_t;
endpackage

//--- rtl/lcdhp_frame_div.sv
// frame rate divider on the system clock
`timescale 1ns/1ps
module lcdhp_frame_div
  import lcdhp_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic resetn_in, // async reset, active low
  output logic tick_out // one pulse per frame
);
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  logic tick_nxt;

  always_comb
  begin
    tick_nxt = (cnt_r == FRAME_DIV_LAST);
    cnt_nxt = tick_nxt ? 12'h000 : cnt_r + 12'h001;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cnt_r <= 12'h000;
      tick_out <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_out <= tick_nxt;
    end
  end
endmodule

//--- tb/lcdhp_host_port_props.sv
// assertions on the lcd host port pins
`timescale 1ns/1ps
module lcdhp_host_port_checker
  import lcdhp_pkg::*;
(
  input wire logic CLOCK_IN, // clock
  input wire logic RESETN_IN, // reset
  input wire logic STROBE_IN, // strobe
  input wire logic REG_SELECT_LINE_IN, // select
  input wire logic READ_WRITE_IN, // read/write
  input wire logic [7:0] PARALLEL_DATA_LINES_OUT, // read data
  input wire logic PARALLEL_DATA_LINES_OE_OUT, // data drive
  input wire logic SUB_ADDRESS_PIN_IN, // strap
  input wire logic [6:0] SERIAL_ADDR_OUT, // address
  input wire logic MEM_WE_OUT, // mem write
  input wire logic INSTR_VALID_OUT, // instr taken
  input wire logic [7:0] INSTR_OUT, // instr register
  input wire logic BUSY_OUT, // busy
  input wire logic FRAME_TICK_OUT // frame
);
  logic [11:0] busy_cnt_r, frame_cnt_r;
  logic seen_r;
  logic wide_r, lo_r, strobe_d_r;
  default clocking @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      busy_cnt_r <= 12'h000;
      frame_cnt_r <= 12'h000;
      seen_r <= 1'h0;
      wide_r <= 1'h1;
      lo_r <= 1'h0;
      strobe_d_r <= 1'h0;
    end
    else
    begin
      busy_cnt_r <= BUSY_OUT ? busy_cnt_r + 12'h001 : 12'h000;
      frame_cnt_r <= FRAME_TICK_OUT ? 12'h000 : frame_cnt_r + 12'h001;
      seen_r <= seen_r | FRAME_TICK_OUT;
      strobe_d_r <= STROBE_IN;
      // nibble phase: function set clears it, narrow strobe falls toggle it
      if (INSTR_VALID_OUT && INSTR_OUT[7:5] == 3'h1)
      begin
        wide_r <= INSTR_OUT[FUNC_DL_BIT];
        lo_r <= 1'h0;
      end
      else if (strobe_d_r && !STROBE_IN && !wide_r)
      begin
        lo_r <= !lo_r;
      end
    end
  end
  property p_instr_sel;
    INSTR_VALID_OUT |-> !REG_SELECT_LINE_IN && !READ_WRITE_IN;
  endproperty
  a_instr_sel: assert property (p_instr_sel) else $error("instr select");
  property p_we;
    MEM_WE_OUT |-> REG_SELECT_LINE_IN && !READ_WRITE_IN ##1 !MEM_WE_OUT;
  endproperty
  a_we: assert property (p_we) else $error("mem write");
  property p_oe;
    $rose(PARALLEL_DATA_LINES_OE_OUT) |-> READ_WRITE_IN && STROBE_IN;
  endproperty
  a_oe: assert property (p_oe) else $error("drive on write");
  property p_refuse;
    INSTR_VALID_OUT |-> !$past(BUSY_OUT);
  endproperty
  a_refuse: assert property (p_refuse) else $error("taken while busy");
  property p_busy_len;
    $fell(BUSY_OUT) |-> busy_cnt_r >= 12'h7CE && busy_cnt_r <= 12'h7D2;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  property p_status;
    // busy bit rides only the first nibble of a narrow status read
    $rose(PARALLEL_DATA_LINES_OE_OUT) && !REG_SELECT_LINE_IN && !lo_r |->
      PARALLEL_DATA_LINES_OUT[7] == BUSY_OUT || PARALLEL_DATA_LINES_OUT[7] == $past(BUSY_OUT);
  endproperty
  a_status: assert property (p_status) else $error("busy bit");
  property p_frame;
    seen_r |-> frame_cnt_r <= FRAME_DIV_LAST && (!FRAME_TICK_OUT || frame_cnt_r == FRAME_DIV_LAST);
  endproperty
  a_frame: assert property (p_frame) else $error("frame period");
  property p_saddr;
    $past(RESETN_IN) |-> SERIAL_ADDR_OUT == {SER_ADDR_HI, $past(SUB_ADDRESS_PIN_IN)};
  endproperty
  a_saddr: assert property (p_saddr) else $error("serial address");
endmodule
bind lcdhp_host_port lcdhp_host_port_checker u_chk (.CLOCK_IN(CLOCK_IN),
  .RESETN_IN(RESETN_IN), .STROBE_IN(STROBE_IN), .REG_SELECT_LINE_IN(REG_SELECT_LINE_IN),
  .READ_WRITE_IN(READ_WRITE_IN), .PARALLEL_DATA_LINES_OUT(PARALLEL_DATA_LINES_OUT),
  .PARALLEL_DATA_LINES_OE_OUT(PARALLEL_DATA_LINES_OE_OUT), .MEM_WE_OUT(MEM_WE_OUT),
  .SUB_ADDRESS_PIN_IN(SUB_ADDRESS_PIN_IN), .SERIAL_ADDR_OUT(SERIAL_ADDR_OUT),
  .INSTR_VALID_OUT(INSTR_VALID_OUT), .INSTR_OUT(INSTR_OUT), .BUSY_OUT(BUSY_OUT),
  .FRAME_TICK_OUT(FRAME_TICK_OUT));

//--- tb/lcdhp_host_model.sv
// host microcontroller model on the parallel bus
`timescale 1ns/1ps
module lcdhp_host_model (
  input wire logic clk_in, // clock
  output logic strobe_out, // strobe
  output logic rs_out, // select
  output logic rw_out, // read/write
  output logic db_oe_out, // host drives data
  output logic [7:0] db_out, // host data
  input wire logic [7:0] db_in // resolved lines
);
  // strobe low, data lines released between accesses
  initial
  begin
    strobe_out = 1'h0;
    rs_out = 1'h1;
    rw_out = 1'h1;
    db_oe_out = 1'h0;
    db_out = 8'h00;
  end
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_in);
    #1 rs_out = rs;
    rw_out = rw;
    db_out = d;
    db_oe_out = !rw;
    repeat (4) @(posedge clk_in);
    #1 strobe_out = 1'h1;
    repeat (8) @(posedge clk_in);
    q = db_in;
    #1 strobe_out = 1'h0;
    repeat (7) @(posedge clk_in);
    #1 db_oe_out = 1'h0;
  endtask
endmodule

//--- tb/lcdhp_host_port_bench.sv
// self-checking bench for the lcd host port
`timescale 1ns/1ps
module lcdhp_host_port_bench;
  import lcdhp_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic strap = 0;
  logic nib = 0;
  logic st, rs, rw, hoe, oe, we, gsel, iv, busy, tick;
  logic [7:0] hd, dout, bus, mrd, wd, ins, q, v, d, cmd;
  logic [6:0] sa, ma, ptr;
  logic [2:0] bias;
  logic [15:0] e;
  logic [15:0] notes[$];
  int fail_count = 0;
  int check_count = 0;
  always #10 clk = ~clk;
  // pull-ups hold released lines high
  assign bus = oe ? dout : (hoe ? hd : 8'hFF);
  assign mrd = {ma, gsel} ^ 8'hA5;
  lcdhp_host_model u_host (.clk_in(clk), .strobe_out(st), .rs_out(rs), .rw_out(rw),
    .db_oe_out(hoe), .db_out(hd), .db_in(bus));
  lcdhp_host_port u_dut (.CLOCK_IN(clk), .RESETN_IN(rstn), .STROBE_IN(st),
    .REG_SELECT_LINE_IN(rs), .READ_WRITE_IN(rw), .PARALLEL_DATA_LINES_IN(bus),
    .PARALLEL_DATA_LINES_OUT(dout), .PARALLEL_DATA_LINES_OE_OUT(oe),
    .SUB_ADDRESS_PIN_IN(strap), .SERIAL_ADDR_OUT(sa), .MEM_RDATA_IN(mrd), .MEM_WE_OUT(we),
    .MEM_GLYPH_SEL_OUT(gsel), .MEM_ADDR_OUT(ma), .MEM_WDATA_OUT(wd), .INSTR_OUT(ins),
    .INSTR_VALID_OUT(iv), .BUSY_OUT(busy), .BIAS_LEVELS_OUT(bias), .FRAME_TICK_OUT(tick));
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    check_count++;
    if (g !== x)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // garbage on the low lines in nibble mode
  task automatic wr(input logic r, input logic [7:0] x);
    if (nib)
    begin
      u_host.xfer(r, 1'h0, {x[7:4], 4'($urandom)}, q);
      u_host.xfer(r, 1'h0, {x[3:0], 4'($urandom)}, q);
    end
    else
      u_host.xfer(r, 1'h0, x, q);
  endtask
  task automatic rd(input logic r, output logic [7:0] x);
    u_host.xfer(r, 1'h1, 8'h00, x);
    if (nib)
    begin
      u_host.xfer(r, 1'h1, 8'h00, q);
      x = {x[7:4], q[7:4]};
    end
  endtask
  // wait for busy low before the next instruction
  task automatic idle();
    repeat (2100)
      if (busy === 1'h1)
        @(posedge clk);
    #1 chk(16'(busy), 16'h0);
  endtask
  // sample mid-cycle, once registered outputs have settled
  always @(negedge clk)
  begin
    if (iv === 1'h1 || we === 1'h1)
    begin
      e = notes.size() ? notes.pop_front() : 16'hFFFF;
      chk(iv ? {8'h01, ins} : {1'h1, ma, wd}, e);
    end
  end
  initial
  begin
    void'($urandom(30716));
    repeat (6) @(posedge clk);
    #1 rstn = 1;
    strap = 1'($urandom);
    repeat (2) @(posedge clk);
    #1 chk(16'(sa), {9'h0, SER_ADDR_HI, strap});
    for (int k = 0; k < 2; k++)
    begin
      ptr = 7'($urandom_range(32));
      d = 8'($urandom);
      cmd = k ? {2'h1, ptr[5:0]} : {1'h1, ptr};
      notes.push_back({8'h01, cmd});
      wr(1'h0, cmd);
      rd(1'h0, v);
      chk(16'(v), {8'h0, 1'h1, ptr});
      // dropped while busy: no note queued
      wr(1'h0, 8'h01);
      idle();
      notes.push_back({1'h1, ptr, d});
      wr(1'h1, d);
      rd(1'h0, v);
      chk(16'(v), {9'h0, ptr + 7'h1});
      rd(1'h1, v);
      chk(16'(v), {8'h0, {ptr + 7'h1, k[0]} ^ 8'hA5});
      rd(1'h0, v);
      chk(16'(v), {9'h0, ptr + 7'h2});
      cmd = k ? 8'h30 : 8'h28;
      notes.push_back({8'h01, cmd});
      wr(1'h0, cmd);
      idle();
      nib = !nib;
      chk(16'(bias), 16'(k ? BIAS_LEVELS_MUX16 : BIAS_LEVELS_MUX32));
    end
    chk(16'(notes.size()), 16'h0);
    final_report();
  end
  // limit about six times the expected run
  initial
  begin
    #1000000;
    fail_count++;
    final_report();
  end
endmodule
